/* File: core/clock_pulse_gen_control.sv */
// Purpose: register file, power-mode sequencer and clock enables of the
//          clock pulse generator
// Assumes: mclk is the system clock; all inputs synchronous to it
// Notes:   bus master clock leaves as an enable; the phi pin toggles at
//          half the system rate while it is live
`timescale 1ns/100ps
module clock_pulse_gen_control
	import clock_gen_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              rstn,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wr_data,
	input  wire logic              wr_en,
	input  wire logic              rd_en,
	output logic      [DATA_W-1:0] rd_data,
	input  wire logic              sleep_exec,
	input  wire logic              standby_select,
	input  wire logic              timer_standby_select,
	input  wire logic              wake_event,
	input  wire logic              hw_standby_n,
	output logic                   phi_out,
	output logic                   phi_oe,
	output logic                   bus_clk_en,
	output logic                   noise_sample_en,
	output logic                   subclock_osc_halt,
	output logic                   feedback_resistor_disable,
	output logic      [1:0]        pll_multiplier_select,
	output logic      [3:0]        power_mode
);

	logic              rst_meta;
	logic              rst_sync_n;
	logic [7:0]        system_clock_control;
	logic [7:0]        low_power_control;
	power_mode_t       mode;
	power_mode_t       sleep_dest;
	power_mode_t       wake_dest;
	power_mode_t       run_mode;
	power_mode_t       direct_target;
	logic              direct_go;
	logic [DIRECT_CNT_W-1:0] direct_cnt;
	logic              hw_standby;
	logic              is_active;
	logic              phi_live;
	logic              settle_mode;
	logic [2:0]        bmc_sel;
	logic [2:0]        noise_sel;
	logic              phi_off;
	logic              direct_flag;
	logic              low_speed;
	logic              bus_tick;
	logic              noise_tick;

	// Reset release through two flops; assertion stays asynchronous
	// Both flops clear together, so a release never splits the design
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			rst_meta   <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rst_meta   <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// Field decode
	always_comb
	begin
		hw_standby  = !hw_standby_n;
		bmc_sel     = system_clock_control[BMC_SEL_LSB +: BMC_SEL_W];
		phi_off     = system_clock_control[PHI_OFF_BIT];
		direct_flag = low_power_control[DIRECT_FLAG_BIT];
		low_speed   = low_power_control[LOW_SPEED_BIT];
		noise_sel   = low_power_control[NOISE_SEL_BIT] ?
			NOISE_DIV4_SEL : NOISE_DIV8_SEL;
		run_mode    = (bmc_sel == BMC_FULL) ?
			mode_high : mode_medium;
		is_active   = (mode == mode_high) || (mode == mode_medium) ||
			(mode == mode_subactive);
	end

	// Clock control register; all bits plain storage
	// Reserved bits are kept, so software reads back what it wrote
	always_ff @(posedge mclk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			system_clock_control <= SYS_CLK_CTRL_RESET;
		else if (hw_standby)
			system_clock_control <= SYS_CLK_CTRL_RESET;
		else if (wr_en && addr == SYS_CLK_CTRL_ADDR)
			system_clock_control <= wr_data;
	end

	// Low-power control; software standby leaves it alone
	// Hardware standby wins over a write in the same cycle
	always_ff @(posedge mclk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			low_power_control <= LOW_PWR_CTRL_RESET;
		else if (hw_standby)
			low_power_control <= LOW_PWR_CTRL_RESET;
		else if (wr_en && addr == LOW_PWR_CTRL_ADDR)
			low_power_control <= wr_data;
	end

	// Read data valid only in the cycle after the strobe
	// Unmapped addresses and idle cycles read as zero
	always_ff @(posedge mclk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			rd_data <= READ_IDLE;
		else if (rd_en)
		begin
			case (addr)
				SYS_CLK_CTRL_ADDR: rd_data <= system_clock_control;
				LOW_PWR_CTRL_ADDR: rd_data <= low_power_control;
				MODE_STATUS_ADDR:  rd_data <= {4'h0, mode};
				default:           rd_data <= READ_IDLE;
			endcase
		end
		else
			rd_data <= READ_IDLE;
	end

	// Where a SLEEP goes from the running modes
	// Halted modes never act on a SLEEP, so they keep their code
	always_comb
	begin
		sleep_dest = mode;
		direct_go  = 1'b0;
		case (mode)
			mode_high, mode_medium:
			begin
				if (!standby_select)
					sleep_dest = mode_sleep;
				else if (!timer_standby_select)
					sleep_dest = mode_sw_standby;
				else if (direct_flag && low_speed)
				begin
					sleep_dest = mode_subactive;
					direct_go  = 1'b1;
				end
				else if (direct_flag)
					sleep_dest = mode_sw_standby;
				else
					sleep_dest = mode_watch;
			end
			mode_subactive:
			begin
				if (!standby_select)
					sleep_dest = mode_subsleep;
				else if (direct_flag && !low_speed)
				begin
					sleep_dest = mode_high;
					direct_go  = 1'b1;
				end
				else if (direct_flag)
					sleep_dest = mode_subsleep;
				else
					sleep_dest = mode_watch;
			end
			default:
			begin
				sleep_dest = mode;
				direct_go  = 1'b0;
			end
		endcase
	end

	// Where a wake-up leads from each halted mode
	// Watch exit follows the low-speed flag; the others resume
	always_comb
	begin
		case (mode)
			mode_sleep:      wake_dest = run_mode;
			mode_sw_standby: wake_dest = run_mode;
			mode_subsleep:   wake_dest = mode_subactive;
			mode_watch:      wake_dest = low_speed ?
				mode_subactive : mode_high;
			default:         wake_dest = mode;
		endcase
	end

	// Power-mode sequencer; hardware standby overrides everything
	// High and medium track the select field on every edge without a SLEEP
	always_ff @(posedge mclk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			mode <= mode_high;
		else if (hw_standby)
			mode <= mode_hw_standby;
		else
		begin
			case (mode)
				mode_hw_standby:
					mode <= mode_high;
				mode_direct:
					if (direct_cnt == DIRECT_LAST)
						mode <= direct_target;
				default:
					if (is_active && sleep_exec)
						mode <= direct_go ? mode_direct : sleep_dest;
					else if (mode == mode_subactive)
						mode <= mode_subactive;
					else if (is_active)
						mode <= run_mode;
					else if (wake_event)
						mode <= wake_dest;
			endcase
		end
	end

	// Destination and dwell of a direct transition
	// Target frozen on entry; later register writes cannot redirect it
	always_ff @(posedge mclk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			direct_target <= mode_high;
			direct_cnt    <= '0;
		end
		else if (mode != mode_direct)
		begin
			direct_target <= sleep_dest;
			direct_cnt    <= '0;
		end
		else
			direct_cnt <= direct_cnt + DIRECT_CNT_W'(1);
	end

	// Modes in which the oscillator settings are re-applied
	always_comb
	begin
		settle_mode = (mode == mode_sw_standby) ||
			(mode == mode_watch) || (mode == mode_subactive);
	end

	// Multiplier and feedback choice reach the oscillator only while in a
	// settling mode, so a live oscillator never sees them change
	always_ff @(posedge mclk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			pll_multiplier_select     <= '0;
			feedback_resistor_disable <= 1'b0;
		end
		else if (settle_mode)
		begin
			pll_multiplier_select     <=
				low_power_control[PLL_SEL_LSB +: PLL_SEL_W];
			feedback_resistor_disable <= low_power_control[FB_CUT_BIT];
		end
	end

	// Subclock oscillator control
	// Level copy only; the oscillator itself lives outside this block
	always_ff @(posedge mclk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			subclock_osc_halt <= 1'b0;
		else
			subclock_osc_halt <= low_power_control[SUB_HALT_BIT];
	end

	// Two generators of one kind, each with its own count: bus master and noise sampling dividers
	clock_tick_divider u_bus_div (
		.clk   (mclk),
		.rst_n (rst_sync_n),
		.sel   (bmc_sel),
		.tick  (bus_tick)
	);

	clock_tick_divider u_noise_div (
		.clk   (mclk),
		.rst_n (rst_sync_n),
		.sel   (noise_sel),
		.tick  (noise_tick)
	);

	// Bus master runs only in high and medium speed; the subclock
	// path is outside this block
	always_ff @(posedge mclk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			bus_clk_en <= 1'b0;
		else
			bus_clk_en <= bus_tick && ((mode == mode_high) ||
				(mode == mode_medium));
	end

	// No sampling once the subclock is halted
	// Enable drops one edge after the halt bit is written
	always_ff @(posedge mclk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			noise_sample_en <= 1'b0;
		else
			noise_sample_en <= noise_tick &&
				!low_power_control[SUB_HALT_BIT];
	end

	// Modes in which the clock pin may run
	// Sleep keeps the pin running although the bus master stops
	always_comb
	begin
		phi_live = !phi_off && (is_active || (mode == mode_sleep) ||
			(mode == mode_subsleep));
	end

	// Clock pin: toggle when live, high otherwise, float in hw standby
	// Enable is high while driving; only hardware standby releases it
	always_ff @(posedge mclk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			phi_out <= 1'b1;
			phi_oe  <= 1'b1;
		end
		else if (mode == mode_hw_standby)
		begin
			phi_out <= 1'b1;
			phi_oe  <= 1'b0;
		end
		else if (phi_live)
		begin
			phi_out <= !phi_out;
			phi_oe  <= 1'b1;
		end
		else
		begin
			phi_out <= 1'b1;
			phi_oe  <= 1'b1;
		end
	end

	// Mode straight from the sequencer flops
	assign power_mode = mode;

endmodule

/* File: core/cpg_pkg.sv */
// Purpose: constants and types of the clock pulse generator control block
// Assumes: 100 MHz mclk, 16-bit register addresses, 8-bit register data
// Notes:   reserved register bits are plain storage
package clock_gen_pkg;

	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;

	// Register addresses and the status word
	localparam logic [15:0] SYS_CLK_CTRL_ADDR = 16'hfde6;
	localparam logic [15:0] LOW_PWR_CTRL_ADDR = 16'hfdec;
	localparam logic [15:0] MODE_STATUS_ADDR  = 16'hfdf0;

	localparam logic [7:0] SYS_CLK_CTRL_RESET = 8'h00;
	localparam logic [7:0] LOW_PWR_CTRL_RESET = 8'h00;
	localparam logic [7:0] READ_IDLE          = 8'h00;

	// Clock control fields
	localparam int PHI_OFF_BIT = 7;
	localparam int BMC_SEL_LSB = 0;
	localparam int BMC_SEL_W   = 3;

	// Low-power control fields
	localparam int DIRECT_FLAG_BIT = 7;
	localparam int LOW_SPEED_BIT   = 6;
	localparam int NOISE_SEL_BIT   = 5;
	localparam int SUB_HALT_BIT    = 4;
	localparam int FB_CUT_BIT      = 3;
	localparam int PLL_SEL_LSB     = 0;
	localparam int PLL_SEL_W       = 2;

	// Divider selections, as powers of two
	localparam logic [2:0] BMC_FULL       = 3'h0;
	localparam logic [2:0] BMC_MAX        = 3'h5;
	localparam logic [2:0] NOISE_DIV8_SEL = 3'h3;
	localparam logic [2:0] NOISE_DIV4_SEL = 3'h2;
	localparam int         DIV_CNT_W      = 5;

	// Direct transition dwell
	localparam int CLK_PERIOD_NS  = 10;
	localparam int DIRECT_TIME_NS = 80;
	localparam int DIRECT_CYCLES  =
		(DIRECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DIRECT_CNT_W   = 4;
	localparam logic [DIRECT_CNT_W-1:0] DIRECT_LAST =
		DIRECT_CNT_W'(DIRECT_CYCLES - 1);

	typedef enum logic [3:0] {
		mode_high,
		mode_medium,
		mode_sleep,
		mode_subactive,
		mode_subsleep,
		mode_sw_standby,
		mode_watch,
		mode_direct,
		mode_hw_standby
	} power_mode_t;

endpackage

/* File: core/clock_tick_divider.sv */
// Purpose: power-of-two tick divider with glitch-free selection change
// Assumes: sel is a power-of-two exponent, values above BMC_MAX clamp
// Notes:   tick is a one-cycle enable, not a derived clock
`timescale 1ns/100ps
module clock_tick_divider
	import clock_gen_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [2:0] sel,
	output logic            tick
);

	logic [DIV_CNT_W-1:0] cnt;
	logic [2:0]           sel_live;
	logic [DIV_CNT_W-1:0] mask;

	// Free-running count shared by every divisor
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt <= '0;
		else
			cnt <= cnt + DIV_CNT_W'(1);
	end

	// Take a new divisor only where all periods end together
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			sel_live <= BMC_FULL;
		else if (&cnt)
			sel_live <= (sel > BMC_MAX) ? BMC_MAX : sel;
	end

	always_comb
	begin
		mask = DIV_CNT_W'((6'h01 << sel_live) - 6'h01);
	end

	// One tick at the end of each divided period
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			tick <= 1'b0;
		else
			tick <= ((cnt & mask) == mask);
	end

endmodule

/* File: testbench/clock_pulse_gen_control_checker.sv */
// Purpose: port assertions of clock_pulse_gen_control
// Assumes: one clock domain, mclk; mode codes as in power_mode_t
// Notes:   quiet for three edges after rstn rises, internal reset lags
`timescale 1ns/100ps
module clock_pulse_gen_control_checker
	import clock_gen_pkg::*;
(
	input wire logic              mclk,
	input wire logic              rstn,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic              rd_en,
	input wire logic [DATA_W-1:0] rd_data,
	input wire logic              wake_event,
	input wire logic              hw_standby_n,
	input wire logic              phi_out,
	input wire logic              phi_oe,
	input wire logic              bus_clk_en,
	input wire logic              noise_sample_en,
	input wire logic              subclock_osc_halt,
	input wire logic [3:0]        power_mode
);
	logic [1:0] up;
	logic [5:0] hi_run;
	logic [5:0] md_run;

	// Settle count after reset release
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			up <= 2'h0;
		else if (up != 2'h3)
			up <= up + 2'h1;
	end

	// Dwell counts; a divisor swap may wait a full wrap of 32
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			hi_run <= 6'h0;
			md_run <= 6'h0;
		end
		else
		begin
			hi_run <= (power_mode != 4'h0) ? 6'h0 :
				(hi_run == 6'h28) ? hi_run : hi_run + 6'h1;
			md_run <= (power_mode != 4'h1) ? 6'h0 :
				(md_run == 6'h28) ? md_run : md_run + 6'h1;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn || up != 2'h3);

	sequence enter_direct;
		power_mode != 4'h7 ##1 power_mode == 4'h7;
	endsequence
	sequence direct_dwell;
		(power_mode == 4'h7) [*8] ##1 power_mode inside {4'h0, 4'h3};
	endsequence
	sequence hws_read;
		!hw_standby_n ##1 !hw_standby_n && rd_en &&
			(addr == SYS_CLK_CTRL_ADDR || addr == LOW_PWR_CTRL_ADDR);
	endsequence

	pin_float_a: assert property (power_mode == 4'h8 |=> !phi_oe)
		else $error("phi pin driven in hardware standby");
	pin_high_a: assert property (
		(power_mode inside {4'h5, 4'h6, 4'h7}) [*2] |-> phi_out)
		else $error("phi pin not high while stopped");
	hws_entry_a: assert property (
		!hw_standby_n |=> power_mode == 4'h8)
		else $error("hardware standby not entered");
	hws_exit_a: assert property (
		hw_standby_n && power_mode == 4'h8 |=> power_mode == 4'h0)
		else $error("hardware standby exit not to high speed");
	hws_clear_a: assert property (hws_read |=> rd_data == 8'h00)
		else $error("register kept in hardware standby");
	bus_full_a: assert property (hi_run == 6'h28 |-> bus_clk_en)
		else $error("bus clock gap at full speed");
	bus_gap_a: assert property (
		md_run == 6'h28 && bus_clk_en |=> !bus_clk_en)
		else $error("bus clock pulses adjacent when divided");
	bus_stop_a: assert property (
		(!(power_mode inside {4'h0, 4'h1})) [*3] |-> !bus_clk_en)
		else $error("bus clock running outside active modes");
	direct_time_a: assert property (enter_direct |-> direct_dwell)
		else $error("direct transition dwell wrong");
	sub_wake_a: assert property (
		power_mode == 4'h4 && wake_event && hw_standby_n
		|=> power_mode == 4'h3)
		else $error("subsleep wake not to subactive");
	noise_halt_a: assert property (
		subclock_osc_halt [*3] |-> !noise_sample_en)
		else $error("subclock sampled while halted");
endmodule

bind clock_pulse_gen_control clock_pulse_gen_control_checker u_chk (
	.mclk, .rstn, .addr, .rd_en, .rd_data, .wake_event, .hw_standby_n,
	.phi_out, .phi_oe, .bus_clk_en, .noise_sample_en, .subclock_osc_halt,
	.power_mode
);

/* File: testbench/clock_pulse_gen_control_test.sv */
// Purpose: self-checking bench of clock_pulse_gen_control
// Assumes: register bus with read data one cycle after the strobe
// Notes:   mode, registers and counts come from a model in the bench
`timescale 1ns/100ps
module clock_pulse_gen_control_test
	import clock_gen_pkg::*;
();
	logic              mclk, rstn, wr_en, rd_en, sleep_exec, wake_event;
	logic              standby_select, timer_standby_select, hw_standby_n;
	logic              phi_out, phi_oe, bus_clk_en, noise_sample_en;
	logic              subclock_osc_halt, feedback_resistor_disable;
	logic [1:0]        pll_multiplier_select;
	logic [3:0]        power_mode;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wr_data, rd_data;
	logic [7:0]        scc, lpc;
	logic [9:0]        steps [11];
	int                n_errors, num_checks, seed, md, tg, i, nb, np, nn;

	clock_pulse_gen_control u_dut (
		.mclk, .rstn, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
		.sleep_exec, .standby_select, .timer_standby_select, .wake_event,
		.hw_standby_n, .phi_out, .phi_oe, .bus_clk_en, .noise_sample_en,
		.subclock_osc_halt, .feedback_resistor_disable,
		.pll_multiplier_select, .power_mode
	);

	// 100 MHz clock
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Hang guard, far beyond the thousand or so cycles needed
	initial
	begin
		#300000;
		n_errors++;
		finish_test();
	end

	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] got, exp);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %s exp %h got %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		wr_en <= 1'b1;
		addr <= a;
		wr_data <= v;
		@(posedge mclk);
		wr_en <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd_en <= 1'b0;
		#1 chk("rd_data", rd_data, e);
		@(posedge mclk);
	endtask

	// Pulses and phi edges over 64 cycles, a multiple of every divisor
	task automatic cnt64();
		logic p;
		p = phi_out;
		nb = 0;
		np = 0;
		nn = 0;
		repeat (64)
		begin
			@(posedge mclk);
			nb += bus_clk_en;
			np += (phi_out != p);
			nn += noise_sample_en;
			p = phi_out;
		end
	endtask

	function automatic int sleep_to(input logic ss, ts);
		tg = (md == 3) ? 0 : 3;
		if (md == 3)
			return !ss ? 4 : (lpc[7] && !lpc[6]) ? 7 : lpc[7] ? 4 : 6;
		return !ss ? 2 : !ts ? 5 : (lpc[7] && lpc[6]) ? 7 : lpc[7] ? 5 : 6;
	endfunction

	task automatic step(input logic [9:0] s);
		lpc = s[9:2];
		wr(LOW_PWR_CTRL_ADDR, lpc);
		standby_select <= s[1];
		timer_standby_select <= s[0];
		sleep_exec <= 1'b1;
		md = sleep_to(s[1], s[0]);
		@(posedge mclk);
		sleep_exec <= 1'b0;
		#1 chk("mode", {4'h0, power_mode}, 8'(md));
		if (md == 7)
		begin
			repeat (8) @(posedge mclk);
			md = tg;
			#1 chk("direct", {4'h0, power_mode}, 8'(md));
		end
		else
		begin
			repeat (4) @(posedge mclk);
			wake_event <= 1'b1;
			@(posedge mclk);
			wake_event <= 1'b0;
			md = (md == 4) ? 3 : (md == 6) ? (lpc[6] ? 3 : 0) :
				int'(scc[2:0] != 3'h0);
			#1 chk("wake", {4'h0, power_mode}, 8'(md));
		end
		@(posedge mclk);
	endtask

	initial
	begin
		{rstn, wr_en, rd_en, sleep_exec, wake_event} = 5'h0;
		{standby_select, timer_standby_select, addr, wr_data} = 26'h0;
		hw_standby_n = 1'b1;
		seed = 49771;
		steps = '{10'h000, 10'h002, 10'h003, 10'h203, 10'h303, 10'h303,
			10'h300, 10'h103, 10'h203, 10'h103, 10'h203};
		repeat (20) @(posedge mclk);
		rstn <= 1'b1;
		repeat (3) @(posedge mclk);
		rd(SYS_CLK_CTRL_ADDR, 8'h00);
		rd(LOW_PWR_CTRL_ADDR, 8'h00);
		rd(16'hfde7, 8'h00);
		rd(MODE_STATUS_ADDR, 8'h00);
		// Random contents, reserved clock bits left zero
		for (i = 0; i < 6; i++)
		begin
			scc = 8'($random(seed)) & 8'h87;
			if (scc[2:0] > 3'h5)
				scc[2] = 1'b0;
			lpc = 8'($random(seed));
			wr(SYS_CLK_CTRL_ADDR, scc);
			wr(LOW_PWR_CTRL_ADDR, lpc);
			rd(SYS_CLK_CTRL_ADDR, scc);
			rd(LOW_PWR_CTRL_ADDR, lpc);
			chk("mode", {4'h0, power_mode}, {7'h0, scc[2:0] != 3'h0});
		end
		wr(LOW_PWR_CTRL_ADDR, 8'h00);
		// Every divisor, phi disabled on odd passes
		for (i = 0; i < 6; i++)
		begin
			scc = {i[0], 4'h0, i[2:0]};
			wr(SYS_CLK_CTRL_ADDR, scc);
			repeat (40) @(posedge mclk);
			cnt64();
			chk("bus", 8'(nb), 8'(64 >> i));
			chk("phi", 8'(np), i[0] ? 8'h00 : 8'h40);
			chk("noise", 8'(nn), 8'h08);
		end
		wr(LOW_PWR_CTRL_ADDR, 8'h20);
		repeat (40) @(posedge mclk); // New divisor waits for a wrap
		cnt64();
		chk("noise", 8'(nn), 8'h10);
		wr(LOW_PWR_CTRL_ADDR, 8'h10);
		cnt64();
		chk("noise", 8'(nn), 8'h00);
		chk("halt", {7'h0, subclock_osc_halt}, 8'h01);
		scc = 8'h00;
		wr(SYS_CLK_CTRL_ADDR, scc);
		md = 0;
		wr(LOW_PWR_CTRL_ADDR, 8'h0b);
		chk("pll", {6'h0, pll_multiplier_select}, 8'h00);
		step(10'h02e);
		chk("pll", {6'h0, pll_multiplier_select}, 8'h03);
		chk("fb", {7'h0, feedback_resistor_disable}, 8'h01);
		for (i = 0; i < 11; i++)
			step(steps[i]);
		rd(LOW_PWR_CTRL_ADDR, lpc);
		scc = 8'h81;
		wr(SYS_CLK_CTRL_ADDR, scc);
		md = 1;
		step(10'h000);
		rd(SYS_CLK_CTRL_ADDR, scc);
		hw_standby_n <= 1'b0;
		repeat (3) @(posedge mclk);
		wr(SYS_CLK_CTRL_ADDR, 8'h05);
		rd(SYS_CLK_CTRL_ADDR, 8'h00);
		rd(LOW_PWR_CTRL_ADDR, 8'h00);
		rd(MODE_STATUS_ADDR, 8'h08);
		#1 chk("oe", {7'h0, phi_oe}, 8'h00);
		chk("mode", {4'h0, power_mode}, 8'h08);
		@(posedge mclk);
		hw_standby_n <= 1'b1;
		@(posedge mclk);
		#1 chk("mode", {4'h0, power_mode}, 8'h00);
		repeat (3) @(posedge mclk);
		finish_test();
	end
endmodule
